//--- core/irct_tx.sv
// file: infrared remote carrier pwm transmitter core
`timescale 1ns/100ps
module irct_tx (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // static control
    input wire irct_pkg::irct_ctrl_t ctrl,
    input wire logic [irct_pkg::CAR_W-1:0] carrierPeriod,
    input wire logic [irct_pkg::CAR_W-1:0] carrierDuty,
    // setting writes (one-cycle strobes with data)
    input wire logic activeLenWr,
    input wire logic [irct_pkg::DAT_W-1:0] activeLenIn,
    input wire logic bitLenWr,
    input wire logic [irct_pkg::DAT_W-1:0] bitLenIn,
    // command strobes
    input wire logic runSetWr,
    input wire logic runClrWr,
    input wire logic counterResetWr,
    input wire logic softResetWr,
    input wire logic activeFlagClrWr,
    input wire logic lengthFlagClrWr,
    // interrupt enables
    input wire logic activeIrqEn,
    input wire logic lengthIrqEn,
    // read back
    output logic [irct_pkg::DAT_W-1:0] dataCount,
    output logic [irct_pkg::DAT_W-1:0] activeLen,
    output logic [irct_pkg::DAT_W-1:0] bitLen,
    output irct_pkg::irct_stat_t status,
    output logic irq,
    // pins
    output logic irTxOut,
    output logic clearPulseOut
);
    import irct_pkg::*;

    logic [CAR_W-1:0] carCnt_q, carCnt_d;
    logic carrier_q, carrier_d;
    logic [DAT_W-1:0] datCnt_q, datCnt_d;
    logic data_q, data_d;
    logic [DAT_W-1:0] activeLen_q, activeLen_d, bitLen_q, bitLen_d;
    logic [DAT_W-1:0] activeBuf_q, activeBuf_d, lengthBuf_q, lengthBuf_d;
    logic activeBusy_q, activeBusy_d, lengthBusy_q, lengthBusy_d;
    logic apFlag_q, apFlag_d, dbFlag_q, dbFlag_d;
    logic run_q, run_d;
    logic softRst_q, softRst_d;
    irct_state_t state_q, state_d;
    logic irq_q, tx_q, clp_q;
    logic clearShown_q, runShown_q;

    // compare sources and match decode
    wire [DAT_W-1:0] apCmp = ctrl.compareBufEn ? activeBuf_q : activeLen_q;
    wire [DAT_W-1:0] dbCmp = ctrl.compareBufEn ? lengthBuf_q : bitLen_q;
    wire running = (state_q == ST_RUN) && run_q;
    wire apMatch = running && (datCnt_q == apCmp);
    wire dbMatch = running && (datCnt_q == dbCmp);

    // carrier compares against the static period and duty
    wire crDutyHit = carCnt_q == carrierDuty;
    wire crPerHit = carCnt_q == carrierPeriod;

    // write acceptance; a refused write leaves the setting and its busy flag alone
    wire enabled = ctrl.moduleEnable;
    wire activeWrOk = activeLenWr && enabled && !(ctrl.compareBufEn && activeBusy_q);
    wire lengthWrOk = bitLenWr && enabled && !(ctrl.compareBufEn && lengthBusy_q);

    // events that steer the counters and the shadows
    wire reload = ctrl.compareBufEn && dbMatch;
    wire oneshotStop = dbMatch && ctrl.oneshotSelect;
    wire clearCnt = (state_q == ST_CLEAR) || softRst_q;

    // output shaping ahead of the pin flops
    wire carGate = ctrl.carrierModEn ? carrier_q : 1'b1;
    wire txRaw = carGate & data_q;
    // clear pulse is high from active match to end of bit
    wire clpRaw = running && !data_q;

    // counter lifecycle
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (counterResetWr && enabled) begin
                    state_d = ST_CLEAR;
                end else if (run_q) begin
                    state_d = ST_RUN;
                end
            end
            ST_CLEAR: state_d = run_q ? ST_RUN : ST_IDLE;
            ST_RUN: begin
                if (counterResetWr && enabled) begin
                    state_d = ST_CLEAR;
                end else if (!run_d) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
        if (softRst_q) begin
            state_d = ST_IDLE;
        end
    end

    // run control and soft reset pulse
    always_comb begin
        run_d = run_q;
        if (runSetWr && enabled) begin
            run_d = 1'b1;
        end
        if (runClrWr) begin
            run_d = 1'b0;
        end
        if (oneshotStop) begin
            run_d = 1'b0;
        end
        if (softRst_q) begin
            run_d = 1'b0;
        end
        softRst_d = softResetWr && !softRst_q;
    end

    // carrier generator
    always_comb begin
        carCnt_d = carCnt_q;
        carrier_d = carrier_q;
        if (clearCnt) begin
            carCnt_d = CAR_ZERO;
            carrier_d = 1'b1;
        end else if (running) begin
            if (crPerHit) begin
                carCnt_d = CAR_ZERO;
                carrier_d = ~carrier_q;
            end else begin
                carCnt_d = carCnt_q + CAR_ONE;
                if (crDutyHit) begin
                    carrier_d = ~carrier_q;
                end
            end
        end
    end

    // data generator
    always_comb begin
        datCnt_d = datCnt_q;
        data_d = data_q;
        if (clearCnt) begin
            datCnt_d = DAT_ZERO;
            data_d = 1'b1;
        end else if (running) begin
            if (dbMatch) begin
                datCnt_d = DAT_ZERO;
                data_d = 1'b1;
            end else begin
                datCnt_d = datCnt_q + DAT_ONE;
                if (apMatch) begin
                    data_d = 1'b0;
                end
            end
        end
    end

    // settings, shadows and busy flags
    always_comb begin
        activeLen_d = activeWrOk ? activeLenIn : activeLen_q;
        bitLen_d = lengthWrOk ? bitLenIn : bitLen_q;
        activeBuf_d = activeBuf_q;
        lengthBuf_d = lengthBuf_q;
        activeBusy_d = activeBusy_q;
        lengthBusy_d = lengthBusy_q;
        if (!ctrl.compareBufEn || !running) begin
            activeBuf_d = activeLen_d; // shadows track while idle or unbuffered
            lengthBuf_d = bitLen_d;
            activeBusy_d = 1'b0;
            lengthBusy_d = 1'b0;
        end else begin
            if (reload) begin
                activeBuf_d = activeLen_q;
                lengthBuf_d = bitLen_q;
                activeBusy_d = 1'b0;
                lengthBusy_d = 1'b0;
            end
            if (activeWrOk) begin
                activeBusy_d = 1'b1;
            end
            if (lengthWrOk) begin
                lengthBusy_d = 1'b1;
            end
        end
    end

    // compare flags, set wins over clear
    always_comb begin
        apFlag_d = apFlag_q;
        dbFlag_d = dbFlag_q;
        if (activeFlagClrWr || softRst_q) begin
            apFlag_d = 1'b0;
        end
        if (lengthFlagClrWr || softRst_q) begin
            dbFlag_d = 1'b0;
        end
        if (apMatch) begin
            apFlag_d = 1'b1;
        end
        if (dbMatch) begin
            dbFlag_d = 1'b1;
        end
    end

    // state registers
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= ST_IDLE;
            run_q <= 1'b0;
            softRst_q <= 1'b0;
            carCnt_q <= CAR_ZERO;
            carrier_q <= 1'b1;
            datCnt_q <= DAT_ZERO;
            data_q <= 1'b1;
        end else begin
            state_q <= state_d;
            run_q <= run_d;
            softRst_q <= softRst_d;
            carCnt_q <= carCnt_d;
            carrier_q <= carrier_d;
            datCnt_q <= datCnt_d;
            data_q <= data_d;
        end
    end

    // setting and flag registers
    always_ff @(posedge clk) begin
        if (srst) begin
            activeLen_q <= DAT_ZERO;
            bitLen_q <= DAT_ZERO;
            activeBuf_q <= DAT_ZERO;
            lengthBuf_q <= DAT_ZERO;
            activeBusy_q <= 1'b0;
            lengthBusy_q <= 1'b0;
            apFlag_q <= 1'b0;
            dbFlag_q <= 1'b0;
        end else begin
            activeLen_q <= activeLen_d;
            bitLen_q <= bitLen_d;
            activeBuf_q <= activeBuf_d;
            lengthBuf_q <= lengthBuf_d;
            activeBusy_q <= activeBusy_d;
            lengthBusy_q <= lengthBusy_d;
            apFlag_q <= apFlag_d;
            dbFlag_q <= dbFlag_d;
        end
    end

    // registered pins and interrupt
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_q <= 1'b0;
            tx_q <= 1'b0;
            clp_q <= 1'b0;
        end else begin
            irq_q <= (apFlag_q && activeIrqEn) || (dbFlag_q && lengthIrqEn);
            tx_q <= running ? (txRaw ^ ctrl.outInvert) : 1'b0;
            clp_q <= clpRaw;
        end
    end

    // status copies of the lifecycle, taken from next state so they match state_q and run_q exactly
    always_ff @(posedge clk) begin
        if (srst) begin
            clearShown_q <= 1'b0;
            runShown_q <= 1'b0;
        end else begin
            clearShown_q <= (state_d == ST_CLEAR);
            runShown_q <= (state_d == ST_RUN) && run_d;
        end
    end

    // read back, straight from registers
    assign dataCount = datCnt_q;
    assign activeLen = activeLen_q;
    assign bitLen = bitLen_q;
    assign status = '{
        countRun: run_q,
        counterReset: clearShown_q,
        softReset: softRst_q,
        dataCountRunning: runShown_q,
        activeBufBusy: activeBusy_q,
        lengthBufBusy: lengthBusy_q,
        activeMatchFlag: apFlag_q,
        lengthMatchFlag: dbFlag_q
    };
    assign irq = irq_q;
    assign irTxOut = tx_q;
    assign clearPulseOut = clp_q;
endmodule : irct_tx

//--- core/irct_pkg.sv
// package: constants and control, status and lifecycle types for the infrared remote carrier pwm transmitter
package irct_pkg;
    localparam int CAR_W = 8;
    localparam int DAT_W = 16;
    localparam logic [CAR_W-1:0] CAR_ZERO = 8'h00;
    localparam logic [DAT_W-1:0] DAT_ZERO = 16'h0000;
    localparam logic [CAR_W-1:0] CAR_ONE = 8'h01;
    localparam logic [DAT_W-1:0] DAT_ONE = 16'h0001;

    // control bits written by software
    typedef struct packed {
        logic moduleEnable;
        logic oneshotSelect;
        logic compareBufEn;
        logic outInvert;
        logic carrierModEn;
    } irct_ctrl_t;

    // status bits shown to software
    typedef struct packed {
        logic countRun;
        logic counterReset;
        logic softReset;
        logic dataCountRunning;
        logic activeBufBusy;
        logic lengthBufBusy;
        logic activeMatchFlag;
        logic lengthMatchFlag;
    } irct_stat_t;

    // counter lifecycle
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CLEAR,
        ST_RUN
    } irct_state_t;
endpackage : irct_pkg

//--- verif/irct_tx_properties.sv
// checker: timing relations watched at the transmitter ports
`timescale 1ns/100ps
module irct_tx_properties (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // controls
    input wire irct_pkg::irct_ctrl_t ctrl,
    input wire logic counterResetWr,
    input wire logic softResetWr,
    input wire logic activeIrqEn,
    input wire logic lengthIrqEn,
    // observed
    input wire logic [15:0] dataCount,
    input wire logic [15:0] activeLen,
    input wire logic [15:0] bitLen,
    input wire irct_pkg::irct_stat_t status,
    input wire logic irq,
    input wire logic irTxOut,
    input wire logic clearPulseOut
);
    import irct_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    // counter clear shows for a while, then releases
    sequence s_clearing;
        status.counterReset ##[1:4] !status.counterReset;
    endsequence
    property p_idle; !status.countRun [*3] |-> !irTxOut && !clearPulseOut; endproperty
    a_idle: assert property (p_idle) else $error("pins active while stopped");
    property p_irq; irq == $past((status.activeMatchFlag & activeIrqEn)
        | (status.lengthMatchFlag & lengthIrqEn)); endproperty
    a_irq: assert property (p_irq) else $error("request not flag and enable");
    property p_act; !ctrl.compareBufEn && $rose(status.activeMatchFlag)
        |-> $past(dataCount) == $past(activeLen); endproperty
    a_act: assert property (p_act) else $error("active flag off its match");
    property p_wrap; $rose(status.lengthMatchFlag) |-> dataCount == DAT_ZERO; endproperty
    a_wrap: assert property (p_wrap) else $error("count not back to zero");
    property p_step; status.dataCountRunning && $past(status.dataCountRunning)
        && dataCount != DAT_ZERO |-> dataCount == $past(dataCount) + DAT_ONE; endproperty
    a_step: assert property (p_step) else $error("count did not step by one");
    property p_one; ctrl.oneshotSelect && $rose(status.lengthMatchFlag) |-> !status.countRun;
    endproperty
    a_one: assert property (p_one) else $error("one-shot kept running");
    property p_busy; ctrl.compareBufEn && status.lengthBufBusy |=> bitLen == $past(bitLen);
    endproperty
    a_busy: assert property (p_busy) else $error("length taken while busy");
    property p_clr; counterResetWr && ctrl.moduleEnable && !softResetWr |-> ##[1:2] s_clearing;
    endproperty
    a_clr: assert property (p_clr) else $error("counter clear not shown");
endmodule : irct_tx_properties

bind irct_tx irct_tx_properties irct_tx_properties_inst (.*);

//--- verif/irct_ir_rx_model.sv
// far side: infrared module that totals the high cycles of both pins
`timescale 1ns/100ps
module irct_ir_rx_model (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // pins from the transmitter
    input wire logic irTxOut,
    input wire logic clearPulseOut,
    // running totals
    output logic [15:0] txHigh,
    output logic [15:0] clrHigh
);
    // the module only listens, so it totals what it sees each cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            txHigh <= 16'h0000;
            clrHigh <= 16'h0000;
        end else begin
            txHigh <= txHigh + {15'h0000, irTxOut};
            clrHigh <= clrHigh + {15'h0000, clearPulseOut};
        end
    end
endmodule : irct_ir_rx_model

//--- verif/irct_tx_bench.sv
// bench: scenario tasks driving the transmitter and judging pins and status
`timescale 1ns/100ps
module irct_tx_bench;
    import irct_pkg::*;
    logic clk, srst, aWr, bWr, aIrq, bIrq, irq, tx, clr;
    irct_ctrl_t ctrl;
    irct_stat_t st;
    logic [7:0] cPer, cDuty;
    logic [5:0] cmd;
    logic [15:0] aIn, bIn, dCnt, aLen, bLen, txH, clrH, t0, c0, hold;
    int n_errors = 0, n_compared = 0, cyc = 0, i;
    irct_tx irct_tx_inst (.clk(clk), .srst(srst), .ctrl(ctrl), .carrierPeriod(cPer),
        .carrierDuty(cDuty), .activeLenWr(aWr), .activeLenIn(aIn), .bitLenWr(bWr),
        .bitLenIn(bIn), .runSetWr(cmd[0]), .runClrWr(cmd[1]), .counterResetWr(cmd[2]),
        .softResetWr(cmd[3]), .activeFlagClrWr(cmd[4]), .lengthFlagClrWr(cmd[5]),
        .activeIrqEn(aIrq), .lengthIrqEn(bIrq), .dataCount(dCnt), .activeLen(aLen),
        .bitLen(bLen), .status(st), .irq(irq), .irTxOut(tx), .clearPulseOut(clr));
    irct_ir_rx_model irct_ir_rx_model_inst (.clk(clk), .srst(srst), .irTxOut(tx),
        .clearPulseOut(clr), .txHigh(txH), .clrHigh(clrH));
    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_errors = n_errors + 1;
            complete_run();
        end
    end
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic pulse(input logic [5:0] m);
        @(posedge clk) cmd <= m;
        @(posedge clk) cmd <= 6'h00;
    endtask : pulse
    task automatic setLen(input logic [15:0] a, input logic [15:0] b);
        @(posedge clk);
        aWr <= 1'b1;
        aIn <= a;
        @(posedge clk);
        aWr <= 1'b0;
        bWr <= 1'b1;
        bIn <= b;
        @(posedge clk);
        bWr <= 1'b0;
    endtask : setLen
    task automatic start(input logic [15:0] a, input logic [15:0] b);
        setLen(a, b);
        pulse(6'h04);
        pulse(6'h01);
        repeat (4) @(posedge clk);
    endtask : start
    task automatic measure(input int n, input logic [15:0] eTx, input logic [15:0] eClr);
        t0 = txH;
        c0 = clrH;
        repeat (n) @(posedge clk);
        chk("tx high cycles", eTx, txH - t0);
        chk("clear pulse high cycles", eClr, clrH - c0);
    endtask : measure
    task automatic dataOnly();
        ctrl <= irct_ctrl_t'(5'h10);
        start(16'h0000, 16'h0005);
        measure(12, 16'h0002, 16'h000a);
        ctrl <= irct_ctrl_t'(5'h12);
        repeat (3) @(posedge clk);
        measure(12, 16'h000a, 16'h000a);
        chk("run flag", 16'h0001, {15'h0000, st.countRun});
        pulse(6'h02);
        repeat (4) @(posedge clk);
        hold = dCnt;
        measure(12, 16'h0000, 16'h0000);
        chk("held count", hold, dCnt);
    endtask : dataOnly
    task automatic carrier();
        ctrl <= irct_ctrl_t'(5'h11);
        cPer <= 8'h03;
        cDuty <= 8'h01;
        start(16'h000e, 16'h000f);
        measure(16, 16'h0008, 16'h0001);
    endtask : carrier
    task automatic buffered();
        ctrl <= irct_ctrl_t'(5'h14);
        pulse(6'h20);
        @(posedge clk);
        for (i = 0; i < 40 && st.lengthMatchFlag !== 1'b1; i++) @(posedge clk);
        setLen(16'h000a, 16'h0014);
        @(posedge clk);
        chk("busy flags", 16'h0003, {14'h0000, st.activeBufBusy, st.lengthBufBusy});
        setLen(16'h0001, 16'h001e);
        @(posedge clk);
        chk("length setting", 16'h0014, bLen);
        chk("active setting", 16'h000a, aLen);
        for (i = 0; i < 40 && st.lengthBufBusy !== 1'b0; i++) @(posedge clk);
        chk("busy flags", 16'h0000, {14'h0000, st.activeBufBusy, st.lengthBufBusy});
        measure(21, 16'h000b, 16'h000a);
        pulse(6'h20);
        @(posedge clk);
        for (i = 0; i < 40 && st.lengthMatchFlag !== 1'b1; i++) @(posedge clk);
        pulse(6'h02);
        ctrl <= irct_ctrl_t'(5'h04);
        setLen(16'h0003, 16'h0009);
        @(posedge clk);
        chk("length while disabled", 16'h0014, bLen);
        chk("active while disabled", 16'h000a, aLen);
    endtask : buffered
    task automatic oneShot();
        pulse(6'h02);
        ctrl <= irct_ctrl_t'(5'h18);
        pulse(6'h30);
        bIrq <= 1'b1;
        start(16'h0002, 16'h0005);
        for (i = 0; i < 40 && st.countRun !== 1'b0; i++) @(posedge clk);
        @(posedge clk);
        chk("one-shot end", 16'h0003, {14'h0000, st.lengthMatchFlag, irq});
        pulse(6'h20);
        repeat (2) @(posedge clk);
        chk("flag cleared", 16'h0002, {13'h0000, st.lengthMatchFlag, st.activeMatchFlag, irq});
        aIrq <= 1'b1;
        repeat (2) @(posedge clk);
        chk("active request", 16'h0001, {15'h0000, irq});
        pulse(6'h10);
        repeat (2) @(posedge clk);
        chk("active request cleared", 16'h0000, {15'h0000, irq});
    endtask : oneShot
    task automatic softRst();
        ctrl <= irct_ctrl_t'(5'h10);
        start(16'h0002, 16'h0005);
        repeat (10) @(posedge clk);
        pulse(6'h08);
        @(posedge clk);
        chk("soft reset shown", 16'h0001, {15'h0000, st.softReset});
        @(posedge clk);
        chk("count after soft reset", 16'h0000, dCnt);
        chk("state after soft reset", 16'h0000, {12'h000, st.countRun, st.activeMatchFlag,
            st.lengthMatchFlag, st.softReset});
    endtask : softRst
    task automatic complete_run();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run
    // main sequence
    initial begin
        srst = 1'b1;
        ctrl = irct_ctrl_t'(5'h00);
        {aWr, bWr, aIrq, bIrq, cmd, aIn, bIn, cPer, cDuty} = '0;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        dataOnly();
        carrier();
        buffered();
        oneShot();
        softRst();
        complete_run();
    end
endmodule : irct_tx_bench
